/* File: inc/ppgd_pkg.sv */
// Package of constants, types and helpers for the pattern generator-detector.
package ppgd_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] PPGD_ADDR_CTRL = 8'h00;
  localparam logic [7:0] PPGD_ADDR_LEN = 8'h04;
  localparam logic [7:0] PPGD_ADDR_TAP = 8'h08;
  localparam logic [7:0] PPGD_ADDR_INS = 8'h0C;
  localparam logic [7:0] PPGD_ADDR_UPD = 8'h10;
  localparam logic [7:0] PPGD_ADDR_DET = 8'h14;
  localparam logic [7:0] PPGD_ADDR_STAT = 8'h18;
  localparam logic [7:0] PPGD_ADDR_MASK = 8'h1C;
  localparam logic [7:0] PPGD_ADDR_STATE = 8'h20;

  // Control register field positions.
  localparam int CTRL_GEN_EN = 0;
  localparam int CTRL_DET_EN = 1;
  localparam int CTRL_PSEL = 2;
  localparam int CTRL_QUASI_RANDOM_MODE = 3;
  localparam int CTRL_TXINV = 4;
  localparam int CTRL_RXINV = 5;
  localparam int CTRL_RESYNC = 6;
  localparam int CTRL_DSEL_LO = 8;
  localparam int CTRL_DSEL_HI = 9;

  // Status and mask bit positions.
  localparam int STAT_GAIN = 0;
  localparam int STAT_LOST = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_OVF = 3;

  // Values after reset.
  localparam logic [9:0] PPGD_CTRL_RST = 10'h000;
  localparam logic [4:0] PPGD_LEN_RST = 5'h00;
  localparam logic [4:0] PPGD_TAP_RST = 5'h00;
  localparam logic [31:0] PPGD_INS_RST = 32'hFFFF_FFFF;
  localparam logic [3:0] PPGD_STAT_RST = 4'h0;
  localparam logic [3:0] PPGD_MASK_RST = 4'h0;

  // Detector counts: last index of the check run, resync window and limit.
  localparam logic [5:0] PPGD_CHECK_LAST = 6'h2F;
  localparam logic [5:0] PPGD_WIN_LAST = 6'h2F;
  localparam logic [2:0] PPGD_RESYNC_LAST = 3'h5;

  // Quasi-random variant: length code and the zero run that forces a one.
  localparam logic [4:0] PPGD_QUASI_RANDOM_MODE_LEN = 5'h13;
  localparam int PPGD_QUASI_RANDOM_MODE_HI = 19;
  localparam int PPGD_QUASI_RANDOM_MODE_LO = 6;

  typedef enum logic [1:0] {
    DET_IDLE = 2'b00,
    DET_LOAD = 2'b01,
    DET_CHECK = 2'b10,
    DET_SYNC = 2'b11
  } ppgd_state_t;

  typedef struct packed {
    logic valid;
    logic data;
  } ppgd_bit_t;

  typedef struct packed {
    logic patSel;
    logic quasi_random_mode;
    logic [4:0] len;
    logic [4:0] tap;
  } ppgd_cfg_t;

  // Single exclusive-OR feedback, or plain recirculation in repetitive mode.
  function automatic logic ppgd_feedback(input logic [31:0] sr,
                                         input ppgd_cfg_t cfg);
    return cfg.patSel ? sr[cfg.len] : (sr[cfg.len] ^ sr[cfg.tap]);
  endfunction : ppgd_feedback

  // Forces a one into the output after a long zero run in quasi-random mode.
  function automatic logic ppgd_quasi_random_mode_force(input logic [31:0] sr,
                                           input ppgd_cfg_t cfg);
    return cfg.quasi_random_mode && !cfg.patSel && (cfg.len == PPGD_QUASI_RANDOM_MODE_LEN) &&
           (sr[PPGD_QUASI_RANDOM_MODE_HI:PPGD_QUASI_RANDOM_MODE_LO] == '0);
  endfunction : ppgd_quasi_random_mode_force

endpackage : ppgd_pkg

/* File: design/ppgd_gen.sv */
// Pattern generator: 32-stage shift register fed by one feedback gate.
`timescale 1ns/1ps
module ppgd_gen
  import ppgd_pkg::*;
(
  input logic ref_clk,
  input logic srst,
  input ppgd_cfg_t cfg,
  input logic [31:0] seed,
  input logic load,
  input logic advance,
  input logic txInv,
  output logic txBit
);

  logic [31:0] sr_reg;
  logic txBit_reg;
  wire fbBit = ppgd_feedback(sr_reg, cfg);
  wire outBit = (fbBit | ppgd_quasi_random_mode_force(sr_reg, cfg)) ^ txInv;

  // Seed loads take priority over shifting; the feedback enters stage 0.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sr_reg <= PPGD_INS_RST;
      txBit_reg <= 1'b0;
    end
    else if (load)
      sr_reg <= seed;
    else if (advance)
    begin
      sr_reg <= {sr_reg[30:0], fbBit};
      txBit_reg <= outBit;
    end
  end

  assign txBit = txBit_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  chk_gen_seed_load: assert property (load |=> sr_reg == $past(seed))
    else $error("Generator did not take its seed.");
  chk_gen_shift_body: assert property (advance && !load |=>
      sr_reg[31:1] == $past(sr_reg[30:0]))
    else $error("Generator stages did not shift.");
  chk_gen_recirc_loop: assert property (advance && !load && cfg.patSel |=>
      sr_reg[0] == $past(sr_reg[cfg.len]))
    else $error("Repetitive loop did not recirculate.");
  chk_gen_xor_taps: assert property (advance && !load && !cfg.patSel |=>
      sr_reg[0] == ($past(sr_reg[cfg.len]) ^ $past(sr_reg[cfg.tap])))
    else $error("Feedback is not the tap exclusive-OR.");
  chk_gen_tx_invert: assert property (advance && !load && !cfg.quasi_random_mode |=>
      txBit == ($past(txInv) ^ sr_reg[0]))
    else $error("Transmit inversion is wrong.");

endmodule : ppgd_gen

/* File: design/ppgd_capture.sv */
// History of the last 32 received bits and its snapshot on update.
`timescale 1ns/1ps
module ppgd_capture
  import ppgd_pkg::*;
(
  input logic ref_clk,
  input logic srst,
  input logic shift,
  input logic bitIn,
  input logic update,
  output logic [31:0] snap
);

  logic [31:0] hist_reg;
  logic [31:0] snap_reg;

  // The newest bit lands in bit 0; a snapshot holds bits before the strobe.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      hist_reg <= 32'h0000_0000;
      snap_reg <= 32'h0000_0000;
    end
    else
    begin
      if (shift)
        hist_reg <= {hist_reg[30:0], bitIn};
      if (update)
        snap_reg <= hist_reg;
    end
  end

  assign snap = snap_reg;

  chk_cap_snapshot: assert property (@(posedge ref_clk) disable iff (srst)
      update |=> snap == $past(hist_reg))
    else $error("Snapshot does not hold prior received bits.");

endmodule : ppgd_capture

/* File: design/ppgd_top.sv */
// Pattern generator and detector with its register slave and interrupt.
// Summary of operation
// - Generator is a 32-stage shift register fed from one exclusive-OR.
// - Pattern select low: length and tap fields pick the exclusive-OR inputs.
// - Pattern select high: register recirculates; length field sets loop.
// - Repetitive mode continuously outputs the insertion pattern, phase free.
// - Repeat detection loads N bits, checks 48 bits, restarts on failure.
// - After repeat lock, count errors and resync as for random patterns.
// - Detector locks to any pattern, never compares with insertion bytes.
// - Update strobe with selector 00 captures the 32 prior received bits.
// - Transmit and receive inversion bits invert generated and received bits; the captured history takes the received bits uninverted.
// - Quasi-random bit turns the order-20 sequence into its variant.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module ppgd_top
  import ppgd_pkg::*;
(
  input logic ref_clk,
  input logic srst,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input ppgd_bit_t rxStream,
  input logic txReady,
  output logic txValid,
  output logic txBit,
  output logic irq
);

  // Bus phase state.
  logic wrPhase_reg;
  logic rdPhase_reg;
  logic rdDone_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg;

  // Software registers.
  logic [9:0] ctrl_reg;
  logic [4:0] len_reg;
  logic [4:0] tap_reg;
  logic [31:0] ins_reg;
  logic [3:0] stat_reg;
  logic [3:0] stat_next;
  logic [3:0] mask_reg;
  logic genLoad_reg;
  logic resyncPrev_reg;

  // Detector state.
  ppgd_state_t state_reg;
  ppgd_state_t stateNext;
  logic [31:0] det_reg;
  logic [31:0] detNext;
  logic [5:0] bitCnt_reg;
  logic [5:0] bitCntNext;
  logic [2:0] winErr_reg;
  logic [2:0] winErrNext;
  logic [31:0] errCnt_reg;
  logic [31:0] errCntNext;
  logic [31:0] errSnap_reg;
  logic [31:0] captured;
  ppgd_cfg_t cfgBus;

  // Address-phase decode and the write strobes of the data phase.
  wire addrPhase = hsel && htrans[1] && hready;
  wire wrStrobe = wrPhase_reg && hready;
  wire wrCtrl = wrStrobe && (addr_reg == PPGD_ADDR_CTRL);
  wire wrLen = wrStrobe && (addr_reg == PPGD_ADDR_LEN);
  wire wrTap = wrStrobe && (addr_reg == PPGD_ADDR_TAP);
  wire wrIns = wrStrobe && (addr_reg == PPGD_ADDR_INS);
  wire wrUpd = wrStrobe && (addr_reg == PPGD_ADDR_UPD);
  wire wrStat = wrStrobe && (addr_reg == PPGD_ADDR_STAT);
  wire wrMask = wrStrobe && (addr_reg == PPGD_ADDR_MASK);
  wire updStrobe = wrUpd && hwdata[0];
  wire anyCfgWrite = wrCtrl || wrLen || wrTap || wrIns;

  // Configuration fields steering both generator and detector.
  wire genEn = ctrl_reg[CTRL_GEN_EN];
  wire detEn = ctrl_reg[CTRL_DET_EN];
  wire [1:0] detSel = ctrl_reg[CTRL_DSEL_HI:CTRL_DSEL_LO];
  assign cfgBus = '{patSel: ctrl_reg[CTRL_PSEL],
    quasi_random_mode: ctrl_reg[CTRL_QUASI_RANDOM_MODE],
    len: len_reg,
    tap: tap_reg};

  // A change of the manual resync bit in either direction restarts the lock.
  wire resyncToggle = ctrl_reg[CTRL_RESYNC] != resyncPrev_reg;

  // Detector prediction from its own register only, never the insertion bytes.
  wire rxBitIn = rxStream.data ^ ctrl_reg[CTRL_RXINV];
  wire detFb = ppgd_feedback(det_reg, cfgBus);
  wire detExp = detFb | ppgd_quasi_random_mode_force(det_reg, cfgBus);
  wire detRun = detEn && rxStream.valid;
  wire bitErr = rxBitIn != detExp;

  // Detector events that feed the sticky status bits.
  wire evtGain = (state_reg == DET_CHECK) && (stateNext == DET_SYNC);
  wire evtLost = (state_reg == DET_SYNC) && (stateNext == DET_LOAD) &&
                 !resyncToggle;
  wire evtErr = (state_reg == DET_SYNC) && detRun && bitErr;
  wire evtOvf = evtErr && (errCnt_reg == 32'hFFFF_FFFF);
  wire [3:0] evtVec = {evtOvf, evtErr, evtLost, evtGain};

  // Read selection; unmapped offsets read as zero.
  wire [31:0] detData = (detSel == 2'b00) ? captured :
                        (detSel == 2'b01) ? errSnap_reg :
                        (detSel == 2'b10) ? {30'h0000_0000, state_reg} :
                        32'h0000_0000;
  wire [31:0] rdMux =
    (addr_reg == PPGD_ADDR_CTRL) ? {22'h00_0000, ctrl_reg} :
    (addr_reg == PPGD_ADDR_LEN) ? {27'h000_0000, len_reg} :
    (addr_reg == PPGD_ADDR_TAP) ? {27'h000_0000, tap_reg} :
    (addr_reg == PPGD_ADDR_INS) ? ins_reg :
    (addr_reg == PPGD_ADDR_DET) ? detData :
    (addr_reg == PPGD_ADDR_STAT) ? {28'h000_0000, stat_reg} :
    (addr_reg == PPGD_ADDR_MASK) ? {28'h000_0000, mask_reg} :
    (addr_reg == PPGD_ADDR_STATE) ? {30'h0000_0000, state_reg} :
    32'h0000_0000;

  // Reads take one wait state so that read data comes from a flip-flop.
  assign hreadyout = !(rdPhase_reg && !rdDone_reg);
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // Bus phase tracking and read data capture.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wrPhase_reg <= 1'b0;
      rdPhase_reg <= 1'b0;
      rdDone_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      if (hready)
      begin
        wrPhase_reg <= addrPhase && hwrite;
        rdPhase_reg <= addrPhase && !hwrite;
        rdDone_reg <= 1'b0;
        if (addrPhase)
          addr_reg <= haddr[7:0];
      end
      else if (rdPhase_reg)
        rdDone_reg <= 1'b1;
      if (rdPhase_reg && !rdDone_reg)
        hrdata_reg <= rdMux;
    end
  end

  // Configuration registers; a write to control, length, tap or insertion reloads the generator seed.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctrl_reg <= PPGD_CTRL_RST;
      len_reg <= PPGD_LEN_RST;
      tap_reg <= PPGD_TAP_RST;
      ins_reg <= PPGD_INS_RST;
      mask_reg <= PPGD_MASK_RST;
      genLoad_reg <= 1'b0;
      resyncPrev_reg <= 1'b0;
    end
    else
    begin
      if (wrCtrl)
        ctrl_reg <= hwdata[9:0];
      if (wrLen)
        len_reg <= hwdata[4:0];
      if (wrTap)
        tap_reg <= hwdata[4:0];
      if (wrIns)
        ins_reg <= hwdata;
      if (wrMask)
        mask_reg <= hwdata[3:0];
      genLoad_reg <= anyCfgWrite;
      resyncPrev_reg <= ctrl_reg[CTRL_RESYNC];
    end
  end

  // Sticky status: a new event wins over a write-one clear.
  assign stat_next = (stat_reg & ~(wrStat ? hwdata[3:0] : 4'h0)) | evtVec;
  assign irq = |(stat_reg & mask_reg);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      stat_reg <= PPGD_STAT_RST;
    else
      stat_reg <= stat_next;
  end

  // Detector next state: load N bits, check a clean run, then track errors.
  always_comb
  begin
    stateNext = state_reg;
    case (state_reg)
      DET_IDLE:
        stateNext = DET_LOAD;
      DET_LOAD:
        if (detRun && (bitCnt_reg == {1'b0, len_reg}))
          stateNext = DET_CHECK;
      DET_CHECK:
        if (detRun && bitErr)
          stateNext = DET_LOAD;
        else if (detRun && (bitCnt_reg == PPGD_CHECK_LAST))
          stateNext = DET_SYNC;
      DET_SYNC:
        if (evtErr && (winErr_reg == PPGD_RESYNC_LAST))
          stateNext = DET_LOAD;
      default:
        stateNext = DET_IDLE;
    endcase
    if (!detEn)
      stateNext = DET_IDLE;
    else if (resyncToggle)
      stateNext = DET_LOAD;
  end

  // Bit counter, window error count and the local pattern register.
  always_comb
  begin
    bitCntNext = bitCnt_reg;
    winErrNext = winErr_reg;
    detNext = det_reg;
    if (stateNext != state_reg)
    begin
      bitCntNext = 6'h00;
      winErrNext = 3'h0;
    end
    else if (detRun)
    begin
      bitCntNext = bitCnt_reg + 6'h01;
      if (evtErr)
        winErrNext = winErr_reg + 3'h1;
      if ((state_reg == DET_SYNC) && (bitCnt_reg == PPGD_WIN_LAST))
      begin
        bitCntNext = 6'h00;
        winErrNext = 3'h0;
      end
    end
    if (detRun && (state_reg == DET_LOAD))
      detNext = {det_reg[30:0], rxBitIn};
    else if (detRun && (state_reg != DET_IDLE))
      detNext = {det_reg[30:0], detFb};
  end

  // Error counter saturates; update or manual resync clear it, error wins.
  always_comb
  begin
    errCntNext = errCnt_reg;
    if (updStrobe || resyncToggle)
      errCntNext = 32'h0000_0000;
    if (evtErr && (errCnt_reg != 32'hFFFF_FFFF))
      errCntNext = errCntNext + 32'h0000_0001;
  end

  // Detector flip-flops.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg <= DET_IDLE;
      det_reg <= 32'h0000_0000;
      bitCnt_reg <= 6'h00;
      winErr_reg <= 3'h0;
      errCnt_reg <= 32'h0000_0000;
      errSnap_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= stateNext;
      det_reg <= detNext;
      bitCnt_reg <= bitCntNext;
      winErr_reg <= winErrNext;
      errCnt_reg <= errCntNext;
      if (updStrobe)
        errSnap_reg <= errCnt_reg;
    end
  end

  // Generator advances whenever the framer takes a bit.
  assign txValid = genEn;

  ppgd_gen u_gen (
    .ref_clk(ref_clk),
    .srst(srst),
    .cfg(cfgBus),
    .seed(ins_reg),
    .load(genLoad_reg),
    .advance(genEn && txReady),
    .txInv(ctrl_reg[CTRL_TXINV]),
    .txBit(txBit)
  );

  // Raw received history for the detector data register.
  ppgd_capture u_capture (
    .ref_clk(ref_clk),
    .srst(srst),
    .shift(rxStream.valid),
    .bitIn(rxStream.data),
    .update(updStrobe),
    .snap(captured)
  );

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence seqRdWait;
    !hreadyout ##1 hreadyout;
  endsequence

  sequence seqResyncDone;
    (state_reg == DET_LOAD) && (errCnt_reg <= 32'h0000_0001);
  endsequence

  chk_bus_read_wait: assert property (addrPhase && !hwrite |=> seqRdWait)
    else $error("Read did not answer after one wait state.");
  chk_det_load_end: assert property (detEn && !resyncToggle &&
      (state_reg == DET_LOAD) && detRun &&
      (bitCnt_reg == {1'b0, len_reg}) |=> state_reg == DET_CHECK)
    else $error("Detector did not leave load after N bits.");
  chk_det_check_fail: assert property (detEn && !resyncToggle &&
      (state_reg == DET_CHECK) && detRun && bitErr |=>
      state_reg == DET_LOAD && bitCnt_reg == 6'h00)
    else $error("Check failure did not restart the load.");
  chk_det_sync_gain: assert property (detEn && !resyncToggle &&
      (state_reg == DET_CHECK) && detRun && !bitErr &&
      (bitCnt_reg == PPGD_CHECK_LAST) |=>
      state_reg == DET_SYNC ##1 stat_reg[STAT_GAIN])
    else $error("Clean check run did not declare sync.");
  chk_err_count_inc: assert property (evtErr && !updStrobe && !resyncToggle &&
      (errCnt_reg != 32'hFFFF_FFFF) |=>
      errCnt_reg == $past(errCnt_reg) + 32'h0000_0001)
    else $error("Error counter did not step on a bit error.");
  chk_manual_resync: assert property (detEn && resyncToggle |=>
      seqResyncDone)
    else $error("Manual resync did not restart and clear.");
  chk_stat_set_wins: assert property (wrStat && hwdata[STAT_ERR] && evtErr |=>
      stat_reg[STAT_ERR])
    else $error("Status clear overrode a new event.");
  chk_det_pred_only: assert property (detRun && (state_reg == DET_SYNC) &&
      (stateNext == DET_SYNC) |=> det_reg[0] == $past(detFb))
    else $error("Locked detector did not run on its own prediction.");

endmodule : ppgd_top

/* File: tb/ppgd_framer_model.sv */
// Framer model that takes generated bits and loops them back as received.
`timescale 1ns/1ps
module ppgd_framer_model
  import ppgd_pkg::*;
(
  input logic ref_clk,
  input logic srst,
  input logic txValid,
  input logic txBit,
  input logic slowMode,
  input logic flipNext,
  output ppgd_bit_t rxStream,
  output logic txReady
);
  logic took;
  logic flipPend;
  logic flipNow;

  // Outputs start quiet before the first clock edge.
  initial
  begin
    rxStream = '0;
    txReady = 1'b0;
  end

  assign flipNow = flipPend | flipNext;

  // Stalls at random when slow; echoes each taken bit, flipped on request.
  // Between bits the data line toggles so a stale value is never reused.
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      txReady <= 1'b0;
      took <= 1'b0;
      flipPend <= 1'b0;
      rxStream <= '0;
    end
    else
    begin
      txReady <= !slowMode || ($urandom_range(3) == 0);
      took <= txValid && txReady;
      rxStream.valid <= took;
      rxStream.data <= took ? (txBit ^ flipNow) : ~rxStream.data;
      flipPend <= flipNow && !took;
    end
  end
endmodule : ppgd_framer_model

/* File: tb/tb_prbs_pattern_gen_detect.sv */
// Self-checking bench for the pattern generator and detector.
`timescale 1ns/1ps
module tb_prbs_pattern_gen_detect
  import ppgd_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic slowMode = 1'b0;
  logic flipNext = 1'b0;
  logic hreadyout, hresp, txReady, txValid, txBit, irq;
  logic [31:0] hrdata, rd, v;
  ppgd_bit_t rxStream;
  int errors = 0;
  int checked = 0;
  logic rxLog[$];
  logic resyncBit = 1'b0;
  // Each entry holds quasi-random bit, invert bit, length and tap fields.
  logic [11:0] prbsTab[5] = '{12'h5CD, 12'h6D1, 12'h081, 12'hA62, 12'h3C2};
  logic [7:0] rwAddr[6] = '{8'h04, 8'h08, 8'h0C, 8'h1C, 8'h00, 8'h40};
  logic [31:0] rwMask[6] = '{32'h0000_001F, 32'h0000_001F, 32'hFFFF_FFFF,
    32'h0000_000F, 32'h0000_03FF, 32'h0000_0000};

  always #5 ref_clk = ~ref_clk;

  ppgd_top dut (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rxStream(rxStream), .txReady(txReady),
    .txValid(txValid), .txBit(txBit), .irq(irq));

  ppgd_framer_model partner (.ref_clk(ref_clk), .srst(srst),
    .txValid(txValid), .txBit(txBit), .slowMode(slowMode),
    .flipNext(flipNext), .rxStream(rxStream), .txReady(txReady));

  // Logs every received bit for the stream checks.
  always @(posedge ref_clk)
    if (rxStream.valid === 1'b1) rxLog.push_back(rxStream.data);

  task automatic stop_test();
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic check_val(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_val

  // Waits for hready at a rising edge under a bounded count.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        errors++;
        stop_test();
      end
      @(posedge ref_clk);
    end
  endtask : wait_ready

  // One single AHB-Lite transfer; read data lands in rd.
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= 32'(a);
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check_val("response", 32'(hresp), 32'h0000_0000);
  endtask : bus

  // Polls a status bit until it is set, with a bounded number of reads.
  task automatic poll_stat(input int b);
    int n;
    n = 0;
    rd = '0;
    while (rd[b] !== 1'b1)
    begin
      n++;
      if (n > 400)
      begin
        errors++;
        stop_test();
      end
      bus(1'b0, PPGD_ADDR_STAT, '0);
    end
  endtask : poll_stat

  // Programs a pattern, toggles the manual resync and waits for lock.
  task automatic setup(input logic [4:0] len, input logic [4:0] tap,
    input logic [31:0] ins, input logic [9:0] ctrl);
    bus(1'b1, PPGD_ADDR_LEN, 32'(len));
    bus(1'b1, PPGD_ADDR_TAP, 32'(tap));
    bus(1'b1, PPGD_ADDR_INS, ins);
    resyncBit = !resyncBit;
    bus(1'b1, PPGD_ADDR_CTRL, 32'({ctrl[9:7], resyncBit, ctrl[5:2], 2'b11}));
    // Stale status is cleared only after the restart, so no old lock leaks in.
    bus(1'b1, PPGD_ADDR_STAT, 32'h0000_000F);
    rxLog.delete();
    poll_stat(STAT_GAIN);
    bus(1'b0, PPGD_ADDR_STATE, '0);
    check_val("lock state", rd, 32'h0000_0003);
    check_val("tx valid", 32'(txValid), 32'h0000_0001);
  endtask : setup

  // Predicts a received bit from earlier ones by the feedback recurrence.
  function automatic logic predict(input int k, input logic [4:0] len,
    input logic [4:0] tap, input logic repeatMode, input logic inv);
    if (repeatMode)
      return rxLog[k - 1 - len];
    return rxLog[k - 1 - len] ^ rxLog[k - 1 - tap] ^ inv;
  endfunction : predict

  // Pulses one bit error request to the framer model.
  task automatic flip();
    flipNext <= 1'b1;
    @(posedge ref_clk);
    flipNext <= 1'b0;
  endtask : flip

  // Main sequence: reset, registers, patterns, errors and interrupt.
  initial
  begin
    void'($urandom(67));
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    for (int a = 0; a <= 36; a += 4)
    begin
      bus(1'b0, 8'(a), '0);
      check_val("reset", rd, (a == 12) ? 32'hFFFF_FFFF : 32'h0000_0000);
    end
    check_val("tx idle", 32'(txValid), 32'h0000_0000);
    repeat (3)
      foreach (rwAddr[i])
      begin
        v = $urandom();
        bus(1'b1, rwAddr[i], v);
        bus(1'b0, rwAddr[i], '0);
        check_val("readback", rd, v & rwMask[i]);
      end
    bus(1'b1, PPGD_ADDR_MASK, '0);
    // Known control value, so the resync bit the bench tracks is the real one.
    bus(1'b1, PPGD_ADDR_CTRL, '0);
    foreach (prbsTab[i])
    begin
      slowMode <= i[0];
      setup(prbsTab[i][9:5], prbsTab[i][4:0], 32'hFFFF_FFFF,
        {2'b01, 2'b00, {2{prbsTab[i][10]}}, prbsTab[i][11], 3'b000});
      if (!prbsTab[i][11])
        for (int k = prbsTab[i][9:5] + 5; k < rxLog.size(); k++)
        begin
          v = 32'(predict(k, prbsTab[i][9:5], prbsTab[i][4:0], 1'b0,
            prbsTab[i][10]));
          check_val("prbs bit", 32'(rxLog[k]), v);
        end
    end
    bus(1'b1, PPGD_ADDR_UPD, 32'h0000_0001);
    bus(1'b1, PPGD_ADDR_STAT, 32'h0000_000F);
    flip();
    poll_stat(STAT_ERR);
    check_val("irq masked", 32'(irq), 32'h0000_0000);
    bus(1'b1, PPGD_ADDR_MASK, 32'h0000_0004);
    @(posedge ref_clk);
    check_val("irq raised", 32'(irq), 32'h0000_0001);
    bus(1'b1, PPGD_ADDR_UPD, 32'h0000_0001);
    bus(1'b0, PPGD_ADDR_DET, '0);
    check_val("error count", rd, 32'h0000_0001);
    bus(1'b1, PPGD_ADDR_STAT, 32'h0000_0004);
    @(posedge ref_clk);
    check_val("irq cleared", 32'(irq), 32'h0000_0000);
    // Eleven close errors put at least six into one detector window.
    repeat (11)
    begin
      flip();
      repeat (4) @(posedge ref_clk);
    end
    poll_stat(STAT_LOST);
    bus(1'b1, PPGD_ADDR_STAT, 32'h0000_000F);
    poll_stat(STAT_GAIN);
    for (int i = 0; i < 2; i++)
    begin
      slowMode <= i[0];
      setup(i ? 5'h0F : 5'h07, 5'h00, i ? 32'hFFFF_0001 : 32'hFFFF_FF01,
        10'h004);
      for (int k = (i ? 20 : 12); k < rxLog.size(); k++)
      begin
        v = 32'(predict(k, i ? 5'h0F : 5'h07, 5'h00, 1'b1, 1'b0));
        check_val("repeat bit", 32'(rxLog[k]), v);
      end
      bus(1'b1, PPGD_ADDR_UPD, 32'h0000_0001);
      bus(1'b0, PPGD_ADDR_DET, '0);
      v = rd;
      rd = v & (32'hFFFF_FFFF >> (i ? 16 : 8));
      check_val("capture period", v >> (i ? 16 : 8), rd);
      check_val("capture ones", 32'($countones(v)), i ? 2 : 4);
    end
    // Generator off, detector on, selector 10: the state view stays locked.
    bus(1'b1, PPGD_ADDR_CTRL, 32'({2'b10, 1'b0, resyncBit, 6'b00_0110}));
    bus(1'b0, PPGD_ADDR_DET, '0);
    check_val("state view", rd, 32'h0000_0003);
    stop_test();
  end
endmodule : tb_prbs_pattern_gen_detect
